/* File: core/pic_priority_irq_ctrl.sv */
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module pic_priority_irq_ctrl #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rst_n,
  // AXI4-Lite write channels
  input  wire logic [ADDR_W-1:0]          s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [ADDR_W-1:0]          s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  // Request sources
  input  wire logic [1:0]                 ext_req_pin,
  input  wire logic [8:0]                 periph_irq,
  // Core side
  input  wire logic                       irq_ack,
  input  wire logic                       irq_reti,
  output logic                            irq_req,
  output logic [pic_pkg::VEC_W-1:0]       irq_vector,
  output logic [pic_pkg::LVL_W-1:0]       irq_level,
  output logic                            idle_mode
);
  import pic_pkg::*;

  // Register file
  logic [7:0] en_pri_q, ph_pri_q, pl_pri_q, en_sec_q, pl_sec_q, ph_sec_q;
  logic       idle_q;
  // Bus state
  logic              awready_q, wready_q, aw_hold_q, w_hold_q, bvalid_q, arready_q, rvalid_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [7:0]        wdata_q;
  logic              wstrb0_q;
  logic [1:0]        bresp_q, rresp_q;
  logic [31:0]       rdata_q;
  // Pin synchronisers and request path
  logic [1:0]        ext_s1_q, ext_s2_q, ext_s3_q, ext_f_q;
  logic [NSRC-1:0]   raw_req, en_vec, lo_vec, hi_vec;
  logic [3:0]        active_q;
  logic [LVL_W-1:0]  cur_lvl;
  logic              offer, accept, do_wr;
  logic              irq_req_q;
  logic [VEC_W-1:0]  irq_vector_q;
  logic [LVL_W-1:0]  irq_level_q;
  logic [IDX_W-1:0]  offer_idx_q;
  logic [2:0]        wr_sel, rd_sel;
  logic [31:0]       rd_word;

  pic_arb_if arb ();

  pic_arbiter u_arbiter (
    .arb (arb.resolver)
  );

  // Address decode; only aligned words of mapped indexes hit
  function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
    logic [7:0] idx;
    idx = a[9:2];
    if (a[1:0] != 2'b00 || a[ADDR_W-1:10] != '0) reg_sel = 3'h0;
    else begin
      case (idx)
        IDX_EN_PRI: reg_sel = 3'h1;
        IDX_PH_PRI: reg_sel = 3'h2;
        IDX_PL_PRI: reg_sel = 3'h3;
        IDX_EN_SEC: reg_sel = 3'h4;
        IDX_PL_SEC: reg_sel = 3'h5;
        IDX_PH_SEC: reg_sel = 3'h6;
        IDX_IDLE:   reg_sel = 3'h7;
        default:    reg_sel = 3'h0; // Status word is read-only, decoded on the read side
      endcase
    end
  endfunction : reg_sel

  assign wr_sel = reg_sel(awaddr_q);
  assign rd_sel = reg_sel(s_axi_araddr);
  assign do_wr  = aw_hold_q && w_hold_q && !bvalid_q;

  // Write channels; address and data may arrive in either order
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= 8'h00;
      wstrb0_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && awready_q) begin
        awaddr_q  <= s_axi_awaddr;
        aw_hold_q <= 1'b1;
        awready_q <= 1'b0;
      end
      if (s_axi_wvalid && wready_q) begin
        wdata_q  <= s_axi_wdata[7:0];
        wstrb0_q <= s_axi_wstrb[0];
        w_hold_q <= 1'b1;
        wready_q <= 1'b0;
      end
      if (do_wr) begin
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= (wr_sel == 3'h0) ? RESP_SLVERR : RESP_OKAY;
      end
      // Ready returns only after the response, so one write at a time
      if (bvalid_q && s_axi_bready) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // Register stores; reserved bits are masked off and read as zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_pri_q <= RST_REG;
      ph_pri_q <= RST_REG;
      pl_pri_q <= RST_REG;
      en_sec_q <= RST_REG;
      pl_sec_q <= RST_REG;
      ph_sec_q <= RST_REG;
    end else if (do_wr && wstrb0_q) begin
      case (wr_sel)
        3'h1:    en_pri_q <= wdata_q & MSK_EN0;
        3'h2:    ph_pri_q <= wdata_q & MSK_PRI0;
        3'h3:    pl_pri_q <= wdata_q & MSK_PRI0;
        3'h4:    en_sec_q <= wdata_q & MSK_SEC;
        3'h5:    pl_sec_q <= wdata_q & MSK_SEC;
        3'h6:    ph_sec_q <= wdata_q & MSK_SEC;
        default: en_pri_q <= en_pri_q;
      endcase
    end
  end

  // Idle bit: hardware clear on acceptance beats a software set
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) idle_q <= 1'b0;
    else if (accept) idle_q <= 1'b0;
    else if (do_wr && wstrb0_q && wr_sel == 3'h7) idle_q <= wdata_q[IDLE_BIT];
  end

  // Read data mux
  always_comb begin
    case (rd_sel)
      3'h1:    rd_word = {24'h000000, en_pri_q};
      3'h2:    rd_word = {24'h000000, ph_pri_q};
      3'h3:    rd_word = {24'h000000, pl_pri_q};
      3'h4:    rd_word = {24'h000000, en_sec_q};
      3'h5:    rd_word = {24'h000000, pl_sec_q};
      3'h6:    rd_word = {24'h000000, ph_sec_q};
      3'h7:    rd_word = {31'h00000000, idle_q};
      default: rd_word = {20'h00000, offer_idx_q, 3'h0, irq_req_q, active_q};
    endcase
  end

  // Read channel; the status word sits outside the write decode
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= RESP_OKAY;
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= (rd_sel == 3'h0 && s_axi_araddr != ADDR_W'({IDX_STAT, 2'b00})) ? 32'h00000000 : rd_word;
      rresp_q   <= (rd_sel == 3'h0 && s_axi_araddr != ADDR_W'({IDX_STAT, 2'b00})) ? RESP_SLVERR : RESP_OKAY;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // External pins: three stages, a change counts once stages two and three agree
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_s1_q <= 2'b00;
      ext_s2_q <= 2'b00;
      ext_s3_q <= 2'b00;
      ext_f_q  <= 2'b00;
    end else begin
      ext_s1_q <= ext_req_pin;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
      for (int i = 0; i < 2; i++) begin
        if (ext_s2_q[i] == ext_s3_q[i]) ext_f_q[i] <= ext_s3_q[i];
      end
    end
  end

  // Sources in polling order; enables and global gate applied here
  assign raw_req = {periph_irq[8:1], ext_f_q[1], periph_irq[0], ext_f_q[0]};
  assign en_vec  = pack_src(en_pri_q, en_sec_q);
  assign lo_vec  = pack_src(pl_pri_q, pl_sec_q);
  assign hi_vec  = pack_src(ph_pri_q, ph_sec_q);
  assign arb.req = raw_req & en_vec & {NSRC{en_pri_q[GLOBAL_BIT]}};

  // Level of each source from its high and low bits
  always_comb begin
    for (int i = 0; i < NSRC; i++) begin
      arb.lvl[i] = {hi_vec[i], lo_vec[i]};
    end
  end

  // Only a strictly higher level may interrupt what is running
  assign cur_lvl = lvl_top(active_q);
  assign offer   = arb.win_valid && (active_q == 4'h0 || arb.win_lvl > cur_lvl);
  assign accept  = irq_ack && irq_req_q;

  // Offer to the core; dropped the cycle after acceptance
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_req_q    <= 1'b0;
      irq_vector_q <= VEC_EXT0;
      irq_level_q  <= 2'h0;
      offer_idx_q  <= SRC_EXT0;
    end else begin
      irq_req_q    <= offer && !accept;
      irq_vector_q <= vec_of(arb.win_idx);
      irq_level_q  <= arb.win_lvl;
      offer_idx_q  <= arb.win_idx;
    end
  end

  // In-progress levels: set on acceptance, top one freed on return
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) active_q <= 4'h0;
    else begin
      active_q <= (active_q & ~((irq_reti && active_q != 4'h0) ? (4'h1 << cur_lvl) : 4'h0))
                  | (accept ? (4'h1 << irq_level_q) : 4'h0);
    end
  end

  // Outputs
  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign irq_req       = irq_req_q;
  assign irq_vector    = irq_vector_q;
  assign irq_level     = irq_level_q;
  assign idle_mode     = idle_q;

  // Checker helpers: last cycle's settings and arbitration slips
  logic [NSRC-1:0] en_prev_q, lo_prev_q, hi_prev_q;
  logic            lvl_viol, ord_viol;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_prev_q   <= '0;
      lo_prev_q   <= '0;
      hi_prev_q   <= '0;
    end else begin
      en_prev_q   <= en_vec;
      lo_prev_q   <= lo_vec;
      hi_prev_q   <= hi_vec;
    end
  end
  always_comb begin
    lvl_viol = 1'b0;
    ord_viol = 1'b0;
    for (int i = 0; i < NSRC; i++) begin
      if (arb.win_valid && arb.req[i] && arb.lvl[i] > arb.win_lvl) lvl_viol = 1'b1;
      if (arb.win_valid && arb.req[i] && arb.lvl[i] == arb.win_lvl && IDX_W'(i) < arb.win_idx) ord_viol = 1'b1;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  chk_disabled_src: assert property (irq_req_q |-> en_prev_q[offer_idx_q])
    else $error("request offered from a disabled source");
  chk_global_gate: assert property (!en_pri_q[GLOBAL_BIT] |=> !irq_req_q)
    else $error("request offered while global gate closed");
  chk_level_map: assert property (irq_req_q |-> irq_level_q == {hi_prev_q[offer_idx_q], lo_prev_q[offer_idx_q]})
    else $error("offered level does not match priority bits");
  chk_fixed_vectors: assert property (irq_req_q && offer_idx_q == SRC_SPI |-> irq_vector_q == 16'h004b)
    else $error("SPI vector wrong");
  chk_std_vectors: assert property (irq_req_q && offer_idx_q == SRC_TMR1 |-> irq_vector_q == 16'h001b)
    else $error("timer 1 vector wrong");
  chk_no_same_preempt: assert property (irq_req_q && $past(active_q) != 4'h0 |-> irq_level_q > lvl_top($past(active_q)))
    else $error("request offered at or below running level");
  chk_top_locked: assert property (active_q[3] |=> !irq_req_q)
    else $error("top level routine preempted");
  chk_level_first: assert property (!lvl_viol)
    else $error("lower level request won over higher");
  chk_poll_order: assert property (!ord_viol)
    else $error("polling order not kept");
  chk_idle_wake: assert property (accept |=> !idle_q)
    else $error("idle bit kept after acceptance");
  chk_nest_record: assert property (accept |=> active_q[$past(irq_level_q)] && !irq_req_q)
    else $error("accepted level not recorded");

  cov_nested: cover property (active_q[2] && accept && irq_level_q == 2'h3);
  cov_return: cover property (irq_reti && active_q != 4'h0 ##1 irq_req_q);
  cov_tie: cover property (arb.win_valid && $countones(arb.req) > 1);
endmodule : pic_priority_irq_ctrl
`default_nettype wire

/* File: core/pic_pkg.sv */
package pic_pkg;
  // Source count and field widths
  localparam int NSRC  = 11;
  localparam int IDX_W = 4;
  localparam int LVL_W = 2;
  localparam int VEC_W = 16;
  localparam int REG_W = 8;

  // Register indexes; byte address is four times the index
  localparam logic [7:0] IDX_EN_PRI = 8'ha8;
  localparam logic [7:0] IDX_PH_PRI = 8'hb7;
  localparam logic [7:0] IDX_PL_PRI = 8'hb8;
  localparam logic [7:0] IDX_EN_SEC = 8'hb1;
  localparam logic [7:0] IDX_PL_SEC = 8'hb2;
  localparam logic [7:0] IDX_PH_SEC = 8'hb3;
  localparam logic [7:0] IDX_IDLE   = 8'h87;
  localparam logic [7:0] IDX_STAT   = 8'hc0;

  // Reset values and writable masks
  localparam logic [7:0] RST_REG  = 8'h00;
  localparam logic [7:0] MSK_EN0  = 8'hff;
  localparam logic [7:0] MSK_PRI0 = 8'h7f;
  localparam logic [7:0] MSK_SEC  = 8'h47;

  // Field positions
  localparam int GLOBAL_BIT = 7;
  localparam int IDLE_BIT   = 0;

  // Source indexes, which are also the polling order
  localparam logic [IDX_W-1:0] SRC_EXT0 = 4'h0;
  localparam logic [IDX_W-1:0] SRC_TMR0 = 4'h1;
  localparam logic [IDX_W-1:0] SRC_EXT1 = 4'h2;
  localparam logic [IDX_W-1:0] SRC_TMR1 = 4'h3;
  localparam logic [IDX_W-1:0] SRC_SER  = 4'h4;
  localparam logic [IDX_W-1:0] SRC_TMR2 = 4'h5;
  localparam logic [IDX_W-1:0] SRC_CNTA = 4'h6;
  localparam logic [IDX_W-1:0] SRC_KBD  = 4'h7;
  localparam logic [IDX_W-1:0] SRC_TWI  = 4'h8;
  localparam logic [IDX_W-1:0] SRC_SPI  = 4'h9;
  localparam logic [IDX_W-1:0] SRC_USB  = 4'ha;

  // Vector addresses
  localparam logic [VEC_W-1:0] VEC_EXT0 = 16'h0003;
  localparam logic [VEC_W-1:0] VEC_TMR0 = 16'h000b;
  localparam logic [VEC_W-1:0] VEC_EXT1 = 16'h0013;
  localparam logic [VEC_W-1:0] VEC_TMR1 = 16'h001b;
  localparam logic [VEC_W-1:0] VEC_SER  = 16'h0023;
  localparam logic [VEC_W-1:0] VEC_TMR2 = 16'h002b;
  localparam logic [VEC_W-1:0] VEC_CNTA = 16'h0033;
  localparam logic [VEC_W-1:0] VEC_KBD  = 16'h003b;
  localparam logic [VEC_W-1:0] VEC_TWI  = 16'h0043;
  localparam logic [VEC_W-1:0] VEC_SPI  = 16'h004b;
  localparam logic [VEC_W-1:0] VEC_USB  = 16'h0053;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Vector address of a source
  function automatic logic [VEC_W-1:0] vec_of(input logic [IDX_W-1:0] idx);
    case (idx)
      SRC_EXT0: vec_of = VEC_EXT0;
      SRC_TMR0: vec_of = VEC_TMR0;
      SRC_EXT1: vec_of = VEC_EXT1;
      SRC_TMR1: vec_of = VEC_TMR1;
      SRC_SER:  vec_of = VEC_SER;
      SRC_TMR2: vec_of = VEC_TMR2;
      SRC_CNTA: vec_of = VEC_CNTA;
      SRC_KBD:  vec_of = VEC_KBD;
      SRC_TWI:  vec_of = VEC_TWI;
      SRC_SPI:  vec_of = VEC_SPI;
      default:  vec_of = VEC_USB;
    endcase
  endfunction : vec_of

  // Gathers one bit per source from a primary and a secondary register
  function automatic logic [NSRC-1:0] pack_src(input logic [7:0] pri, input logic [7:0] sec);
    pack_src = {sec[6], sec[2], sec[1], sec[0], pri[6:0]};
  endfunction : pack_src

  // Highest level marked in an in-progress set
  function automatic logic [LVL_W-1:0] lvl_top(input logic [3:0] act);
    if (act[3]) lvl_top = 2'h3;
    else if (act[2]) lvl_top = 2'h2;
    else if (act[1]) lvl_top = 2'h1;
    else lvl_top = 2'h0;
  endfunction : lvl_top
endpackage : pic_pkg

/* File: core/pic_arb_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface pic_arb_if;
  import pic_pkg::*;
  logic [NSRC-1:0]             req;
  logic [NSRC-1:0][LVL_W-1:0]  lvl;
  logic                        win_valid;
  logic [IDX_W-1:0]            win_idx;
  logic [LVL_W-1:0]            win_lvl;
  modport resolver (input req, input lvl, output win_valid, output win_idx, output win_lvl);
  modport requester (output req, output lvl, input win_valid, input win_idx, input win_lvl);
endinterface : pic_arb_if
`default_nettype wire

/* File: core/pic_arbiter.sv */
`timescale 1ns/100ps
`default_nettype none
module pic_arbiter (
  // Request set in, winner out
  pic_arb_if.resolver arb
);
  import pic_pkg::*;

  // Scan from the last polled source down, so a lower index wins a tie
  always_comb begin
    logic             v;
    logic [IDX_W-1:0] idx;
    logic [LVL_W-1:0] lv;
    v   = 1'b0;
    idx = '0;
    lv  = '0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (arb.req[i] && (!v || arb.lvl[i] >= lv)) begin
        v   = 1'b1;
        idx = IDX_W'(i);
        lv  = arb.lvl[i];
      end
    end
    arb.win_valid = v;
    arb.win_idx   = idx;
    arb.win_lvl   = lv;
  end
endmodule : pic_arbiter
`default_nettype wire

/* File: verification/pic_core_model.sv */
`timescale 1ns/100ps
`default_nettype none
module pic_core_model (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Offer from the controller
  input  wire logic        irq_req,
  input  wire logic [15:0] irq_vector,
  // Bench control
  input  wire logic        accept_en,
  input  wire logic [3:0]  ack_wait,
  input  wire logic        reti_cmd,
  // Answers to the controller, and the taken vector for the bench
  output logic             irq_ack,
  output logic             irq_reti,
  output logic [15:0]      got_vec
);
  logic [3:0] wait_q;

  // Accept a standing offer after a chosen delay; a one-cycle pulse, never without an offer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_ack <= 1'b0;
      wait_q  <= 4'h0;
      got_vec <= 16'h0000;
    end else if (irq_ack || !irq_req || !accept_en) begin
      irq_ack <= 1'b0;
      wait_q  <= 4'h0;
    end else if (wait_q == ack_wait) begin
      irq_ack <= 1'b1;
      got_vec <= irq_vector; // Vector fetched with the ack
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end

  // Return from the routine, one pulse per bench command
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_reti <= 1'b0;
    end else begin
      irq_reti <= reti_cmd;
    end
  end
endmodule : pic_core_model
`default_nettype wire

/* File: verification/tb_pic_priority_irq_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fail_count++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module tb_pic_priority_irq_ctrl;
  import pic_pkg::*;
  logic        sys_clk, rst_n;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp, lvl, rsp;
  logic [1:0]  ext_pin;
  logic [8:0]  periph;
  logic        ack, reti, req, idle, accept_en, reti_cmd;
  logic [15:0] vec, got_vec;
  logic [3:0]  ack_wait;
  logic [7:0]  rd;
  int          fail_count, n_checks;
  // Vectors in pin order: ext0, ext1, timer0, timer1, serial, timer2, counter array, kbd, TWI, SPI, USB
  logic [15:0] vt [11] = '{16'h0003, 16'h0013, 16'h000b, 16'h001b, 16'h0023, 16'h002b,
                           16'h0033, 16'h003b, 16'h0043, 16'h004b, 16'h0053};

  pic_priority_irq_ctrl i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ext_req_pin(ext_pin), .periph_irq(periph), .irq_ack(ack), .irq_reti(reti),
    .irq_req(req), .irq_vector(vec), .irq_level(lvl), .idle_mode(idle));

  pic_core_model i_core (
    .sys_clk(sys_clk), .rst_n(rst_n), .irq_req(req), .irq_vector(vec), .accept_en(accept_en),
    .ack_wait(ack_wait), .reti_cmd(reti_cmd), .irq_ack(ack), .irq_reti(reti), .got_vec(got_vec));

  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Verdict and end of run
  task automatic conclude;
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude

  // Register write; both channels offered together, each released when taken
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    int n;
    awaddr <= {2'b00, idx, 2'b00};
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge sys_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    rsp = bresp; // Response ready stays high between writes
    if (n == 40) begin fail_count++; conclude(); end
  endtask : wr

  // Register read
  task automatic rdr(input logic [7:0] idx);
    int n;
    araddr <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge sys_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rd = rdata[7:0];
    rsp = rresp; // Read ready stays high between reads
    if (n == 40) begin fail_count++; conclude(); end
  endtask : rdr

  // Bounded wait for the offer to reach a level
  task automatic wait_req(input logic v);
    int n;
    for (n = 0; n < 30 && req !== v; n++) @(posedge sys_clk);
    if (n == 30) begin fail_count++; conclude(); end
  endtask : wait_req

  // Let the core model take the current offer
  task automatic take(input logic [3:0] dly);
    int n;
    ack_wait <= dly;
    accept_en <= 1'b1;
    for (n = 0; n < 30 && ack !== 1'b1; n++) @(posedge sys_clk);
    accept_en <= 1'b0;
    if (n == 30) begin fail_count++; conclude(); end
    @(posedge sys_clk);
  endtask : take

  initial begin
    fail_count = 0;
    n_checks = 0;
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'h1;
    {ext_pin, periph, accept_en, reti_cmd} = '0;
    ack_wait = 4'h0;
    rst_n = 1'b0;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    // Reset values and refused places
    rdr(IDX_EN_PRI); `CHK(rd, 8'h00)
    rdr(IDX_PH_PRI); `CHK(rd, 8'h00)
    rdr(IDX_PL_PRI); `CHK(rd, 8'h00)
    rdr(8'h10); `CHK(rsp, RESP_SLVERR)
    wr(8'h10, 8'hff); `CHK(rsp, RESP_SLVERR)
    // Priority bits read back; software never sets the reserved bit
    wr(IDX_PL_PRI, 8'h7f); rdr(IDX_PL_PRI); `CHK(rd, 8'h7f)
    wr(IDX_PH_PRI, 8'h7f); rdr(IDX_PH_PRI); `CHK(rd, 8'h7f)
    wr(IDX_PL_PRI, 8'h00);
    wr(IDX_PH_PRI, 8'h00);
    // Gate alone, then source enable without gate: nothing offered
    wr(IDX_EN_PRI, 8'h80);
    periph <= 9'h001;
    repeat (8) @(posedge sys_clk);
    `CHK(req, 1'b0)
    wr(IDX_EN_PRI, 8'h02);
    repeat (8) @(posedge sys_clk);
    `CHK(req, 1'b0)
    wr(IDX_EN_PRI, 8'h82);
    wait_req(1'b1); `CHK(vec, 16'h000b)
    periph <= 9'h000;
    // Every source alone gives its own vector
    wr(IDX_EN_PRI, 8'hff); rdr(IDX_EN_PRI); `CHK(rd, 8'hff)
    wr(IDX_EN_SEC, 8'h47);
    for (int p = 0; p < 11; p++) begin
      wait_req(1'b0);
      {periph, ext_pin} <= 11'h001 << p;
      wait_req(1'b1); `CHK(vec, vt[p])
      {periph, ext_pin} <= 11'h000;
    end
    wait_req(1'b0);
    // All at level 0: polling order picks external 0
    {periph, ext_pin} <= 11'h7ff;
    wait_req(1'b1);
    repeat (6) @(posedge sys_clk); // Pin requests lag the same-clock sources
    `CHK(vec, 16'h0003)
    // Timer 1 at level 2 beats serial at level 1
    wr(IDX_PH_PRI, 8'h08);
    wr(IDX_PL_PRI, 8'h10);
    repeat (4) @(posedge sys_clk);
    `CHK(vec, 16'h001b)
    `CHK(lvl, 2'h2)
    take(4'h3); `CHK(got_vec, 16'h001b)
    repeat (6) @(posedge sys_clk);
    `CHK(req, 1'b0)
    // External 1 at level 3 preempts; accepting wakes from idle
    wr(IDX_IDLE, 8'h01); `CHK(idle, 1'b1)
    wr(IDX_PH_PRI, 8'h0c);
    wr(IDX_PL_PRI, 8'h14);
    wait_req(1'b1); `CHK(vec, 16'h0013)
    `CHK(lvl, 2'h3)
    take(4'h0); `CHK(idle, 1'b0)
    rdr(IDX_STAT); `CHK(rd, 8'h0c)
    // Timer 0 also at level 3 waits while level 3 runs
    wr(IDX_PH_PRI, 8'h0e);
    wr(IDX_PL_PRI, 8'h16);
    repeat (8) @(posedge sys_clk);
    `CHK(req, 1'b0)
    // Return frees level 3; polling puts timer 0 ahead of external 1
    reti_cmd <= 1'b1;
    @(posedge sys_clk);
    reti_cmd <= 1'b0;
    wait_req(1'b1); `CHK(vec, 16'h000b)
    // Clearing the gate withdraws the offer
    wr(IDX_EN_PRI, 8'h7f);
    wait_req(1'b0); `CHK(req, 1'b0)
    conclude();
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    conclude();
  end
endmodule : tb_pic_priority_irq_ctrl
`default_nettype wire
